//--- verilog/line_prot_switch_ctrl.sv
/*
  Top of the line protection switch controller: priority evaluation of
  switch requests, lock-in counting and hold, register slave and interrupt.
  Assumes one clock, inputs synchronous to it, and a plain register port.
*/
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "line_prot_defs.svh"

// Overview of operation
// - Select only receive line locally, no far end
// - Switch on line alarm or remote command
// - Default order: absent, freeze, forced, fail, degrade, manual
// - High order: absent, freeze, protfail, forced, workfail
// - Protection fail keeps working line despite forced
// - Freeze ignored when lock-in is unused
// - Degrade switches at threshold only when included
// - Manual mode refuses command to alarmed line
// - Forced mode command selects even alarmed line
// - Count threshold 1 to 255, default 4
// - Watch window 1 to 60 minutes, default 10
// - Hold time 1 to 48 hours, default 24
// - Freeze when switches exceed count (1 to 254) within window; 255 never freezes
// - Release on hold expiry, setting change, unused
// - Lock-in state readable as status
// - Absent spare unit overrides every request
module line_prot_switch_ctrl #(
  parameter logic [31:0] TICK_CYCLES = 32'(`ONE_SEC_PS / `CLK_PERIOD_PS)
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CLK_EN_I,
  input wire line_prot_pkg::line_alarm_s ALARM_I,
  input wire line_prot_pkg::remote_cmd_s REMOTE_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic SELECTED_LINE_O,
  output logic FREEZE_ACTIVE_O,
  output logic IRQ_O
);
  import line_prot_pkg::*;

  // Elaboration check of the second prescaler
  if (TICK_CYCLES < 32'h0000_0002) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Line fails or degrades: any alarm that makes it unfit
  function automatic logic line_bad(input logic fail, input logic degr);
    line_bad = fail | degr;
  endfunction

  // Register address hit, for writes and reads
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [3:0] ctrl_r;                 // Mode and option bits
  logic [7:0] frz_count_r;            // Lock-in switch count threshold
  logic [5:0] frz_window_r;           // Lock-in watch window, minutes
  logic [5:0] frz_hold_r;             // Lock-in hold, hours
  logic [7:0] degr_thr_r;             // Degrade error level threshold
  logic cmd_act_r;                    // Stored operator command present
  logic cmd_line_r;                   // Line named by stored command
  logic [`IRQ_WIDTH-1:0] irq_stat_r;  // Sticky events
  logic [`IRQ_WIDTH-1:0] irq_en_r;    // Event enables
  logic [31:0] rdata_r;               // Read data, one cycle after strobe
  logic sel_r;                        // Selected_line line
  logic irq_r;                        // Interrupt output flop
  logic frz_act_r;                    // Lock-in hold output flop
  freeze_state_e frz_state_r;         // Lock-in state
  logic [31:0] tick_cnt_r;            // Second prescaler
  logic [7:0] sw_cnt_r;               // Switchovers in current window
  logic [17:0] sec_cnt_r;             // Seconds in window or hold

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire wr_ctrl = WR_I & hit(ADDR_I, `REG_CTRL);
  wire wr_cmd = WR_I & hit(ADDR_I, `REG_COMMAND);
  wire wr_frz = WR_I & hit(ADDR_I, `REG_FREEZE);
  wire wr_degr = WR_I & hit(ADDR_I, `REG_DEGRADE);
  wire wr_iclr = WR_I & hit(ADDR_I, `REG_IRQ_CLR);
  wire wr_ien = WR_I & hit(ADDR_I, `REG_IRQ_EN);

  wire maint_override_mode = ctrl_r[`CTRL_MAINT_BIT];
  wire protection_fail_priority_sel = ctrl_r[`CTRL_PFAIL_BIT];
  wire degrade_include_sel = ctrl_r[`CTRL_DEGR_BIT];
  wire freeze_used = ctrl_r[`CTRL_FREEZE_BIT];

  // Field values written to the freeze register, zero kept out of range
  wire [7:0] w_count = WDATA_I[`FRZ_COUNT_LSB +: 8];
  wire [5:0] w_window = WDATA_I[`FRZ_WINDOW_LSB +: 6];
  wire [5:0] w_hold = WDATA_I[`FRZ_HOLD_LSB +: 6];
  wire [7:0] cnt_ok = (w_count == 8'h00) ? 8'h01 : w_count;
  wire [5:0] win_ok = (w_window == 6'h00) ? 6'h01 :
                      (w_window > `FRZ_WINDOW_MAX) ? `FRZ_WINDOW_MAX : w_window;
  wire [5:0] hold_ok = (w_hold == 6'h00) ? 6'h01 :
                       (w_hold > `FRZ_HOLD_MAX) ? `FRZ_HOLD_MAX : w_hold;

  // ****************************************************************
  // Request evaluation
  // ****************************************************************
  // degrade counts only when included
  wire work_degr = degrade_include_sel & (ALARM_I.work_err_level >= degr_thr_r);
  wire prot_degr = degrade_include_sel & (ALARM_I.prot_err_level >= degr_thr_r);
  wire signal_fail = ALARM_I.working_line_fail ^ ALARM_I.protection_line_fail;
  wire signal_degrade = (work_degr ^ prot_degr) &
                        ~ALARM_I.working_line_fail & ~ALARM_I.protection_line_fail;
  // Line that is failing or degrading; the request names the other one.
  // With exactly one line bad, the protection flag alone tells which.
  wire fail_line = ALARM_I.protection_line_fail;
  wire degr_line = prot_degr;

  // A remote command is a level: it applies while held and is never cleared
  // here, whereas the stored operator command is dropped on refusal.
  // remote command joins the operator command path
  wire cmd_any = cmd_act_r | REMOTE_I.valid;
  wire cmd_tgt = REMOTE_I.valid ? REMOTE_I.line : cmd_line_r;
  wire tgt_bad = cmd_tgt ? line_bad(ALARM_I.protection_line_fail, prot_degr) :
                           line_bad(ALARM_I.working_line_fail, work_degr);
  // forced mode turns the command into a forced switch
  wire forced_switch_request = cmd_any & maint_override_mode;
  // manual mode refuses a command to an alarmed line
  wire manual_refuse = cmd_any & ~maint_override_mode & tgt_bad;
  wire manual_switch_request = cmd_any & ~maint_override_mode & ~tgt_bad;
  // freeze request only while lock-in is used
  wire switch_freeze_request = freeze_used & (frz_state_r == FRZ_HOLD);
  wire spare_unit_absent = ALARM_I.spare_unit_absent;

  // Priority chain: the first true branch decides the wanted line. When no
  // branch fires the selection stays put, so switching is non-revertive.
  // Both lines failed holds the selection in the default order unless forced; the high order picks the working line.
  logic want_line;
  logic want_valid;
  always_comb begin
    want_line = sel_r;
    want_valid = 1'b0;
    // absent spare unit pins the working line
    if (spare_unit_absent) begin
      want_line = LINE_WORK;
      want_valid = 1'b1;
    end else if (switch_freeze_request) begin
      want_line = sel_r;
      want_valid = 1'b1;
    end else if (protection_fail_priority_sel) begin
      if (ALARM_I.protection_line_fail) begin
        want_line = LINE_WORK;
        want_valid = 1'b1;
      end else if (forced_switch_request) begin
        want_line = cmd_tgt;
        want_valid = 1'b1;
      end else if (ALARM_I.working_line_fail) begin
        want_line = LINE_PROT;
        want_valid = 1'b1;
      end else if (signal_degrade) begin
        want_line = ~degr_line;
        want_valid = 1'b1;
      end else if (manual_switch_request) begin
        want_line = cmd_tgt;
        want_valid = 1'b1;
      end
    end else begin
      if (forced_switch_request) begin
        want_line = cmd_tgt;
        want_valid = 1'b1;
      end else if (signal_fail) begin
        want_line = ~fail_line;
        want_valid = 1'b1;
      end else if (signal_degrade) begin
        want_line = ~degr_line;
        want_valid = 1'b1;
      end else if (manual_switch_request) begin
        want_line = cmd_tgt;
        want_valid = 1'b1;
      end
    end
  end

  // change only when the top request names the other line
  wire do_switch = want_valid & (want_line != sel_r);
  // Refusal reported unless the absent spare or a freeze decides
  wire refuse_evt = manual_refuse & ~spare_unit_absent & ~switch_freeze_request;

  // ****************************************************************
  // Lock-in timing
  // ****************************************************************
  // The prescaler runs freely while lock-in is used, so the first second of a
  // window or hold may be short by up to one tick period; with whole
  // minutes and whole hours that error is negligible.
  // Counts are kept in seconds so one counter serves both phases.
  wire sec_tick = (tick_cnt_r == TICK_CYCLES - 32'h0000_0001);
  wire [17:0] win_secs = 18'(frz_window_r) * `SEC_PER_MIN;
  wire [17:0] hold_secs = 18'(frz_hold_r) * `SEC_PER_HOUR;
  // Any freeze register write releases, even of equal values, so software can end a hold
  // without knowing the current settings.
  // setting change or unused releases at once
  wire frz_reset = wr_frz | (wr_ctrl & (WDATA_I[`CTRL_FREEZE_BIT] != freeze_used)) | ~freeze_used;
  // entry once a count below 255 is exceeded in the window; a count of 255 never enters
  wire frz_enter = (frz_state_r == FRZ_WATCH) & do_switch & ((sw_cnt_r + 8'h01) > frz_count_r) &
                   (sw_cnt_r != 8'hFF);
  wire win_end = (frz_state_r == FRZ_WATCH) & sec_tick & (sec_cnt_r + 18'h00001 >= win_secs);
  wire hold_end = (frz_state_r == FRZ_HOLD) & sec_tick & (sec_cnt_r + 18'h00001 >= hold_secs);
  wire release_evt = (frz_state_r == FRZ_HOLD) & (hold_end | frz_reset);

  freeze_state_e frz_state_nxt;
  logic [7:0] sw_cnt_nxt;
  logic [17:0] sec_cnt_nxt;
  // Lock-in next state
  always_comb begin
    frz_state_nxt = frz_state_r;
    sw_cnt_nxt = sw_cnt_r;
    sec_cnt_nxt = sec_tick ? sec_cnt_r + 18'h00001 : sec_cnt_r;
    case (frz_state_r)
      FRZ_IDLE: begin
        // First switch opens a watch window
        sec_cnt_nxt = 18'h00000;
        if (do_switch & freeze_used) begin
          frz_state_nxt = FRZ_WATCH;
          sw_cnt_nxt = 8'h01;
        end
      end
      FRZ_WATCH: begin
        if (frz_enter) begin
          frz_state_nxt = FRZ_HOLD;
          sec_cnt_nxt = 18'h00000;
        end else if (win_end) begin
          frz_state_nxt = FRZ_IDLE;
          sw_cnt_nxt = 8'h00;
        end else if (do_switch) begin
          sw_cnt_nxt = sw_cnt_r + 8'h01;
        end
      end
      FRZ_HOLD: begin
        if (hold_end) begin
          frz_state_nxt = FRZ_IDLE;
          sw_cnt_nxt = 8'h00;
        end
      end
      default: begin
        frz_state_nxt = FRZ_IDLE;
      end
    endcase
    if (frz_reset) begin
      frz_state_nxt = FRZ_IDLE;
      sw_cnt_nxt = 8'h00;
      sec_cnt_nxt = 18'h00000;
    end
  end

  // ****************************************************************
  // Events and read mux
  // ****************************************************************
  wire [`IRQ_WIDTH-1:0] evt = {release_evt, refuse_evt, frz_enter, do_switch};
  // Set wins over clear
  wire [`IRQ_WIDTH-1:0] irq_stat_nxt = evt | (irq_stat_r & ~(wr_iclr ? WDATA_I[`IRQ_WIDTH-1:0] : 4'h0));
  wire [3:0] ctrl_nxt = wr_ctrl ? WDATA_I[3:0] : ctrl_r;
  wire [1:0] frz_code = (frz_state_r == FRZ_HOLD) ? 2'h2 : (frz_state_r == FRZ_WATCH) ? 2'h1 : 2'h0;
  wire [31:0] status_word = {8'h00, sw_cnt_r, 12'h000, cmd_act_r, frz_code, sel_r};
  wire [31:0] rd_mux =
    hit(ADDR_I, `REG_CTRL) ? {28'h0000000, ctrl_r} :
    hit(ADDR_I, `REG_COMMAND) ? {30'h00000000, cmd_act_r, cmd_line_r} :
    hit(ADDR_I, `REG_FREEZE) ? {10'h000, frz_hold_r, 2'h0, frz_window_r, frz_count_r} :
    hit(ADDR_I, `REG_DEGRADE) ? {24'h000000, degr_thr_r} :
    hit(ADDR_I, `REG_STATUS) ? status_word :
    hit(ADDR_I, `REG_IRQ_STAT) ? {28'h0000000, irq_stat_r} :
    hit(ADDR_I, `REG_IRQ_EN) ? {28'h0000000, irq_en_r} : 32'h0000_0000;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_r <= `CTRL_RESET;
      frz_count_r <= `FRZ_COUNT_RESET;
      frz_window_r <= `FRZ_WINDOW_RESET;
      frz_hold_r <= `FRZ_HOLD_RESET;
      degr_thr_r <= `DEGR_THR_RESET;
      irq_en_r <= 4'h0;
    end else if (CLK_EN_I) begin
      ctrl_r <= ctrl_nxt;
      if (wr_frz) begin
        frz_count_r <= cnt_ok;
        frz_window_r <= win_ok;
        frz_hold_r <= hold_ok;
      end
      if (wr_degr) begin
        degr_thr_r <= WDATA_I[7:0];
      end
      if (wr_ien) begin
        irq_en_r <= WDATA_I[`IRQ_WIDTH-1:0];
      end
    end
  end

  // A new go beats a refusal in the same cycle; the refusal repeats next
  // cycle if the new target is also unfit.
  // Operator command: held until cancelled or refused
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cmd_act_r <= 1'b0;
      cmd_line_r <= 1'b0;
    end else if (CLK_EN_I) begin
      if (wr_cmd & WDATA_I[`CMD_GO_BIT]) begin
        cmd_act_r <= 1'b1;
        cmd_line_r <= WDATA_I[`CMD_LINE_BIT];
      end else if ((wr_cmd & WDATA_I[`CMD_CANCEL_BIT]) | (refuse_evt & cmd_act_r & ~REMOTE_I.valid)) begin
        cmd_act_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Selection, lock-in and outputs
  // ****************************************************************
  // reset to working line and clear lock-in
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sel_r <= LINE_WORK;
      frz_state_r <= FRZ_IDLE;
      sw_cnt_r <= 8'h00;
      sec_cnt_r <= 18'h00000;
      tick_cnt_r <= 32'h0000_0000;
    end else if (CLK_EN_I) begin
      if (do_switch) begin
        sel_r <= want_line;
      end
      frz_state_r <= frz_state_nxt;
      sw_cnt_r <= sw_cnt_nxt;
      sec_cnt_r <= sec_cnt_nxt;
      tick_cnt_r <= (sec_tick | frz_reset) ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end

  // Interrupt status, read data and output flops
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_stat_r <= 4'h0;
      rdata_r <= 32'h0000_0000;
      irq_r <= 1'b0;
      frz_act_r <= 1'b0;
    end else if (CLK_EN_I) begin
      irq_stat_r <= irq_stat_nxt;
      rdata_r <= RD_I ? rd_mux : 32'h0000_0000;
      irq_r <= |(irq_stat_nxt & irq_en_r);
      // Hold flag tracks the lock-in state register
      frz_act_r <= (frz_state_nxt == FRZ_HOLD);
    end
  end

  assign RDATA_O = rdata_r;
  assign SELECTED_LINE_O = sel_r;
  assign FREEZE_ACTIVE_O = frz_act_r;
  assign IRQ_O = irq_r;

endmodule // line_prot_switch_ctrl

//--- verilog/line_prot_defs.svh
/*
  Constants of the line protection switch controller: register offsets,
  field positions, reset values and timing figures.
  Assumes it is included by bare name from the top module and the bench.
*/
`ifndef LINE_PROT_DEFS_SVH
`define LINE_PROT_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define REG_CTRL      8'h00
`define REG_COMMAND   8'h04
`define REG_FREEZE    8'h08
`define REG_DEGRADE   8'h0C
`define REG_STATUS    8'h10
`define REG_IRQ_STAT  8'h14
`define REG_IRQ_CLR   8'h18
`define REG_IRQ_EN    8'h1C

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTRL_MAINT_BIT   0
`define CTRL_PFAIL_BIT   1
`define CTRL_DEGR_BIT    2
`define CTRL_FREEZE_BIT  3
`define CTRL_RESET       4'h8

// ****************************************************************
// Command register fields
// ****************************************************************
`define CMD_LINE_BIT     0
`define CMD_GO_BIT       1
`define CMD_CANCEL_BIT   2

// ****************************************************************
// Freeze configuration fields and reset values
// ****************************************************************
`define FRZ_COUNT_LSB    0
`define FRZ_WINDOW_LSB   8
`define FRZ_HOLD_LSB     16
`define FRZ_COUNT_RESET  8'h04
`define FRZ_WINDOW_RESET 6'h0A
`define FRZ_HOLD_RESET   6'h18
`define FRZ_WINDOW_MAX   6'h3C
`define FRZ_HOLD_MAX     6'h30
`define DEGR_THR_RESET   8'h80

// ****************************************************************
// Interrupt bits
// ****************************************************************
`define IRQ_SWITCH_BIT   0
`define IRQ_FREEZE_BIT   1
`define IRQ_REFUSE_BIT   2
`define IRQ_RELEASE_BIT  3
`define IRQ_WIDTH        4

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_PS    64'h0000_0000_0000_1388
`define ONE_SEC_PS       64'h0000_00E8_D4A5_1000
`define SEC_PER_MIN      18'h0003C
`define SEC_PER_HOUR     18'h00E10

`endif

//--- verilog/line_prot_pkg.sv
/*
  Types of the line protection switch controller.
  Assumes line_prot_defs.svh is on the include path.
*/
package line_prot_pkg;

  // Line naming: working line in slot 1, protection line in slot 2
  typedef enum logic {LINE_WORK, LINE_PROT} line_e;

  // Alarm and measurement inputs from the two optical line interfaces
  typedef struct packed {
    logic       spare_unit_absent;
    logic       working_line_fail;
    logic       protection_line_fail;
    logic [7:0] work_err_level;
    logic [7:0] prot_err_level;
  } line_alarm_s;

  // Remote switch command
  typedef struct packed {
    logic valid;
    logic line;
  } remote_cmd_s;

  // Lock-in state machine states
  typedef enum logic [1:0] {FRZ_IDLE, FRZ_WATCH, FRZ_HOLD} freeze_state_e;

endpackage

//--- bench/line_side_model.sv
/*
  Far side model: two optical line interfaces and a remote switch source.
  Assumes the bench sets the levels through the two tasks below.
*/
`timescale 1ns/1ps
module line_side_model (
  input wire logic clk_i,
  output line_prot_pkg::line_alarm_s alarm_o,
  output line_prot_pkg::remote_cmd_s remote_o
);
  import line_prot_pkg::*;
  // Quiet lines at time zero
  initial begin
    alarm_o = '0;
    remote_o = '0;
  end
  // alarm levels change right after an edge
  task automatic set_alarm(input line_alarm_s a);
    @(posedge clk_i);
    alarm_o <= a;
  endtask
  // remote command held as a level
  task automatic set_remote(input remote_cmd_s r);
    @(posedge clk_i);
    remote_o <= r;
  endtask
endmodule // line_side_model

//--- bench/line_prot_switch_ctrl_assertions.sv
/*
  Port checker of the line protection switch controller.
  Assumes it is bound into the top module and one clock domain.
*/
`timescale 1ns/1ps
`include "line_prot_defs.svh"
module line_prot_switch_ctrl_assertions #(
  parameter logic [31:0] TICK_CYCLES = 32'h4
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CLK_EN_I,
  input wire line_prot_pkg::line_alarm_s ALARM_I,
  input wire line_prot_pkg::remote_cmd_s REMOTE_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic SELECTED_LINE_O,
  input wire logic FREEZE_ACTIVE_O,
  input wire logic IRQ_O
);
  import line_prot_pkg::*;
  logic [3:0] ctrl_r; // Shadow of control bits
  logic en0_r; // Shadow of switchover enable
  wire ctrl_wr = CLK_EN_I && WR_I && ADDR_I == `REG_CTRL;
  wire en_wr = CLK_EN_I && WR_I && ADDR_I == `REG_IRQ_EN;
  // Follow software writes
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_r <= `CTRL_RESET;
      en0_r <= 1'h0;
    end else begin
      if (ctrl_wr) ctrl_r <= WDATA_I[3:0];
      if (en_wr) en0_r <= WDATA_I[`IRQ_SWITCH_BIT];
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  property p_absent;
    CLK_EN_I && ALARM_I.spare_unit_absent |=> !SELECTED_LINE_O;
  endproperty
  a_absent: assert property (p_absent) else $error("absent spare not honoured");
  property p_reset;
    $fell(RST_I) |-> !SELECTED_LINE_O && !FREEZE_ACTIVE_O;
  endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
  property p_rdata;
    CLK_EN_I && !RD_I |=> RDATA_O == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data without read");
  property p_stall;
    !CLK_EN_I |=> $stable(SELECTED_LINE_O) && $stable(FREEZE_ACTIVE_O);
  endproperty
  a_stall: assert property (p_stall) else $error("change while disabled");
  property p_frz_wr;
    CLK_EN_I && WR_I && ADDR_I == `REG_FREEZE |=> !FREEZE_ACTIVE_O;
  endproperty
  a_frz_wr: assert property (p_frz_wr) else $error("hold kept after setting");
  property p_unused;
    !ctrl_r[`CTRL_FREEZE_BIT] |=> !FREEZE_ACTIVE_O;
  endproperty
  a_unused: assert property (p_unused) else $error("hold while unused");
  property p_hold;
    FREEZE_ACTIVE_O && !ALARM_I.spare_unit_absent && !WR_I |=> FREEZE_ACTIVE_O |-> $stable(SELECTED_LINE_O);
  endproperty
  a_hold: assert property (p_hold) else $error("switch during hold");
  property p_pfail;
    CLK_EN_I && !WR_I && ctrl_r[`CTRL_PFAIL_BIT] && ALARM_I.protection_line_fail && !FREEZE_ACTIVE_O
      |=> !SELECTED_LINE_O;
  endproperty
  a_pfail: assert property (p_pfail) else $error("protection fail not first");
  property p_irq;
    $changed(SELECTED_LINE_O) && en0_r && $past(en0_r) |-> IRQ_O;
  endproperty
  a_irq: assert property (p_irq) else $error("switch without interrupt");
endmodule // line_prot_switch_ctrl_assertions
bind line_prot_switch_ctrl line_prot_switch_ctrl_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .CLK_EN_I(CLK_EN_I), .ALARM_I(ALARM_I), .REMOTE_I(REMOTE_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .SELECTED_LINE_O(SELECTED_LINE_O), .FREEZE_ACTIVE_O(FREEZE_ACTIVE_O), .IRQ_O(IRQ_O));

//--- bench/line_prot_switch_ctrl_tb.sv
/*
  Self-checking bench of the line protection switch controller.
  Assumes the checker is bound and the line model drives alarms.
*/
`timescale 1ns/1ps
`include "line_prot_defs.svh"
`define CHK(a, e) chk(32'(a), 32'(e))
module line_prot_switch_ctrl_tb;
  import line_prot_pkg::*;
  localparam logic [31:0] TICK = 32'h4; // Short second
  localparam logic [7:0] ZR [4] = '{`REG_IRQ_EN, `REG_STATUS, `REG_IRQ_STAT, 8'h20};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic clk_en = 1'h1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [31:0] rdata;
  logic [31:0] rdv; // Last read word
  logic sel;
  logic frz;
  logic irq;
  line_alarm_s alarm;
  remote_cmd_s remote;
  int mismatches = 0;
  int checks = 0;
  line_side_model i_line_side_model (.clk_i(clk), .alarm_o(alarm), .remote_o(remote));
  line_prot_switch_ctrl #(.TICK_CYCLES(TICK)) i_line_prot_switch_ctrl (
    .CORE_CLK_I(clk), .RST_I(rst), .CLK_EN_I(clk_en), .ALARM_I(alarm), .REMOTE_I(remote),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SELECTED_LINE_O(sel), .FREEZE_ACTIVE_O(frz), .IRQ_O(irq));
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  // Compare and count
  function automatic void chk(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, a, e);
    end
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle register write
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // Read; data stand in the next cycle only
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    rdv = rdata;
  endtask
  // Flags {absent, work fail, prot fail} and working error level
  task automatic al(input logic [2:0] f, input logic [7:0] lv);
    i_line_side_model.set_alarm(line_alarm_s'({f, lv, 8'h00}));
    step(2);
  endtask
  task automatic rm(input logic [1:0] r);
    i_line_side_model.set_remote(remote_cmd_s'(r));
    step(2);
  endtask
  task automatic t_reset();
    `CHK(sel, 1'h0);
    `CHK(frz, 1'h0);
    rdr(`REG_CTRL);
    `CHK(rdv, `CTRL_RESET);
    rdr(`REG_FREEZE);
    `CHK(rdv, {10'h0, `FRZ_HOLD_RESET, 2'h0, `FRZ_WINDOW_RESET, `FRZ_COUNT_RESET});
    rdr(`REG_DEGRADE);
    `CHK(rdv, `DEGR_THR_RESET);
    wrr(8'h20, 32'hFFFFFFFF);
    wrr(`REG_STATUS, 32'hFFFFFFFF);
    foreach (ZR[i]) begin
      rdr(ZR[i]);
      `CHK(rdv, 32'h0);
    end
    $display("test reset done");
  endtask
  task automatic t_fail();
    wrr(`REG_CTRL, 32'h0);
    wrr(`REG_IRQ_EN, 32'h1);
    @(posedge clk);
    clk_en <= 1'h0;
    al(3'h2, 8'h00);
    `CHK(sel, 1'h0);
    @(posedge clk);
    clk_en <= 1'h1;
    step(2);
    `CHK(sel, 1'h1);
    `CHK(irq, 1'h1);
    rdr(`REG_IRQ_STAT);
    `CHK(rdv[`IRQ_SWITCH_BIT], 1'h1);
    wrr(`REG_IRQ_CLR, 32'hF);
    step(2);
    `CHK(irq, 1'h0);
    al(3'h0, 8'h00);
    $display("test fail done");
  endtask
  task automatic t_forced();
    al(3'h2, 8'h00);
    wrr(`REG_CTRL, 32'h1);
    wrr(`REG_COMMAND, 32'h2);
    step(2);
    `CHK(sel, 1'h0);
    wrr(`REG_COMMAND, 32'h4);
    step(2);
    `CHK(sel, 1'h1);
    al(3'h1, 8'h00);
    `CHK(sel, 1'h0);
    wrr(`REG_COMMAND, 32'h3);
    step(2);
    `CHK(sel, 1'h1);
    wrr(`REG_CTRL, 32'h3);
    step(2);
    `CHK(sel, 1'h0);
    wrr(`REG_COMMAND, 32'h4);
    al(3'h0, 8'h00);
    wrr(`REG_CTRL, 32'h0);
    $display("test forced done");
  endtask
  task automatic t_manual();
    al(3'h1, 8'h00);
    wrr(`REG_COMMAND, 32'h3);
    step(2);
    `CHK(sel, 1'h0);
    rdr(`REG_IRQ_STAT);
    `CHK(rdv[`IRQ_REFUSE_BIT], 1'h1);
    al(3'h0, 8'h00);
    wrr(`REG_IRQ_CLR, 32'hF);
    wrr(`REG_COMMAND, 32'h3);
    step(2);
    `CHK(sel, 1'h1);
    wrr(`REG_COMMAND, 32'h4);
    rm(2'h2);
    `CHK(sel, 1'h0);
    rm(2'h0);
    $display("test manual done");
  endtask
  task automatic t_degrade();
    al(3'h0, 8'h80);
    `CHK(sel, 1'h0);
    al(3'h0, 8'h7F);
    wrr(`REG_CTRL, 32'h4);
    step(2);
    `CHK(sel, 1'h0);
    al(3'h0, 8'h80);
    `CHK(sel, 1'h1);
    al(3'h0, 8'h00);
    wrr(`REG_CTRL, 32'h0);
    $display("test degrade done");
  endtask
  task automatic t_spare();
    wrr(`REG_CTRL, 32'h1);
    wrr(`REG_COMMAND, 32'h3);
    al(3'h6, 8'h00);
    `CHK(sel, 1'h0);
    wrr(`REG_COMMAND, 32'h4);
    wrr(`REG_CTRL, 32'h0);
    al(3'h0, 8'h00);
    $display("test spare done");
  endtask
  task automatic t_lockin();
    wrr(`REG_FREEZE, 32'h00FFFFFF);
    rdr(`REG_FREEZE);
    `CHK(rdv, 32'h00303CFF);
    wrr(`REG_FREEZE, 32'h0);
    rdr(`REG_FREEZE);
    `CHK(rdv, 32'h00010101);
    wrr(`REG_CTRL, 32'h8);
    rm(2'h3);
    `CHK(sel, 1'h1);
    rm(2'h2);
    `CHK({frz, sel}, 2'h2);
    rdr(`REG_STATUS);
    `CHK(rdv[2:1], 2'h2);
    rm(2'h3);
    step(4);
    `CHK(sel, 1'h0);
    wrr(`REG_CTRL, 32'h0);
    step(2);
    `CHK({frz, sel}, 2'h1);
    wrr(`REG_FREEZE, 32'h0);
    wrr(`REG_CTRL, 32'h8);
    rm(2'h2);
    rm(2'h3);
    `CHK(frz, 1'h1);
    step(int'(3600 * TICK) - 16);
    `CHK(frz, 1'h1);
    step(32);
    `CHK(frz, 1'h0);
    rm(2'h0);
    $display("test lockin done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_fail();
    t_forced();
    t_manual();
    t_degrade();
    t_spare();
    t_lockin();
    complete_run();
  end
endmodule // line_prot_switch_ctrl_tb
